// *** rx_irq_consts.svh ***
// named offsets, field positions, reset values and codes for the rx status latch
`ifndef RX_IRQ_CONSTS_SVH
`define RX_IRQ_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_W 16
`define OFS_LINK_EVENT 16'h1AF6
`define OFS_PACKET_EVENT 16'h1AF7
`define OFS_CHECKSUM_EDGE 16'h1AF8
`define OFS_PACKET_EDGE 16'h1AF9

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_BIT 1'b0

// ****************************************
// byte lanes inside the flag vector
// ****************************************
`define LANE_LINK 0
`define LANE_PACKET 1
`define LANE_CHECKSUM 2
`define LANE_EDGE 3
`define LANE_W 8
`define FLAG_W 32

// ****************************************
// link event byte fields
// ****************************************
`define BIT_CABLE 5
`define BIT_PLL_LOCK 4
`define BIT_CLK_DET 3
`define BIT_STEREO 2
`define BIT_AV_MUTE 1
`define BIT_LINK_MODE 0
`define LINK_SRC_W 6

// ****************************************
// packet event byte fields
// ****************************************
`define BIT_GEN_CTL 7
`define BIT_GAMUT 6
`define BIT_ISRC2 5
`define BIT_ISRC1 4
`define BIT_VENDOR 3
`define BIT_MPEG 2
`define BIT_SRC_DESC 1
`define BIT_VIDEO_INFO 0
`define PKT_SRC_W 8
`define PKT_EDGE_W 7

// ****************************************
// checksum edge byte fields, and packet edge byte header error bit
// ****************************************
`define BIT_CKS_HI 5
`define BIT_CKS_LO 2
`define CKS_W 4
`define BIT_COLOUR 1
`define BIT_CLK_CHANGE 0
`define BIT_HDR_ERR 7

// ****************************************
// interrupt pin field
// ****************************************
`define PIN_FIELD_W 3
`define PIN_RX_IDX 2

`endif

// *** rx_irq_pkg.sv ***
// types shared by the rx status latch modules
package rx_irq_pkg;

  // ****************************************
  // change detector phase
  // ****************************************
  typedef enum logic [0:0]
  {
    PH_PRIME = 1'b0,
    PH_RUN = 1'b1
  } phase_e;

  // ****************************************
  // interrupt pin drive mode
  // ****************************************
  typedef enum logic [1:0]
  {
    PIN_OFF = 2'b00,
    PIN_PUSH = 2'b01,
    PIN_DRAIN = 2'b10
  } pin_mode_e;

  typedef logic [7:0] byte_t;

  // ****************************************
  // top level state
  // ****************************************
  typedef struct packed
  {
    byte_t rd_data;
    logic rd_valid;
    logic irq_raw;
    logic pin_o;
    logic pin_oe;
  } top_state_s;

endpackage

// *** flag_bank_if.sv ***
// carrier between the flag bank and its user
`timescale 1ns/1ps
interface flag_bank_if #(parameter int W = 32);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport owner (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// *** status_flag_bank.sv ***
// sticky flag bank, set wins over clear
`timescale 1ns/1ps
`include "rx_irq_consts.svh"
module status_flag_bank #(
  parameter int W = `FLAG_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // flags
  flag_bank_if.owner bank
);
  import rx_irq_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] flags;
  } bank_state_s;

  bank_state_s st_r;
  bank_state_s st_nxt;

  generate
    if (W < 1)
    begin : g_chk
      $error("flag bank width must be positive");
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.flags = (st_r.flags & ~bank.clr) | bank.set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bank.flags = st_r.flags;
endmodule

// *** change_detector.sv ***
// flags any bit of a level vector that differs from its last sample
`timescale 1ns/1ps
module change_detector #(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels in, one cycle change pulses out
  input wire logic [W-1:0] level,
  output logic [W-1:0] change
);
  import rx_irq_pkg::*;

  typedef struct packed
  {
    phase_e phase;
    logic [W-1:0] prev;
  } det_state_s;

  det_state_s st_r;
  det_state_s st_nxt;

  generate
    if (W < 1)
    begin : g_chk
      $error("change detector width must be positive");
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = level;
    change = '0;
    case (st_r.phase)
      PH_PRIME:
      begin
        st_nxt.phase = PH_RUN;
      end
      PH_RUN:
      begin
        change = level ^ st_r.prev;
      end
      default:
      begin
        st_nxt.phase = PH_PRIME;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{phase: PH_PRIME, prev: '0};
    else
      st_r <= st_nxt;
  end
endmodule

// *** rx_interrupt_status_latch.sv ***
// latched receiver interrupt status flags with read port and interrupt pin
//
// Contract
// - cable detect change sets latched flag
// - pll lock change sets latched flag
// - clock detect change sets latched flag
// - stereo video change sets latched flag
// - av mute change sets latched flag
// - link mode change sets latched flag
// - general control packet change sets flag
// - gamut, isrc1, isrc2 each own level flag
// - four info frame detect flags
// - four info frame checksum error edge flags
// - colour depth change sets edge flag
// - clock detect change sets edge flag
// - unknown packet header error sets flag
// - gamut, isrc1, isrc2 each own edge flag
// - four info frame edge detect flags
// - flags stay set until cleared
// - raw request when masked flag set
// - rx interrupt drives third pin field
`timescale 1ns/1ps
`include "rx_irq_consts.svh"
module rx_interrupt_status_latch #(
  parameter int CD_W = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link status levels, cable, pll, clock, stereo, mute, mode
  input wire logic [`LINK_SRC_W-1:0] link_status,
  // packet and frame status levels
  input wire logic [`PKT_SRC_W-1:0] packet_status,
  // received colour depth mode
  input wire logic [CD_W-1:0] colour_depth,
  // checksum error pulses, vendor, mpeg, source desc, video info
  input wire logic [`CKS_W-1:0] checksum_err,
  // uncorrectable unknown packet header error pulse
  input wire logic header_err,
  // mask bits per register
  input wire rx_irq_pkg::byte_t mask_link,
  input wire rx_irq_pkg::byte_t mask_packet,
  input wire rx_irq_pkg::byte_t mask_checksum,
  input wire rx_irq_pkg::byte_t mask_edge,
  // clear pulses per register
  input wire rx_irq_pkg::byte_t clr_link,
  input wire rx_irq_pkg::byte_t clr_packet,
  input wire rx_irq_pkg::byte_t clr_checksum,
  input wire rx_irq_pkg::byte_t clr_edge,
  // interrupt pin enable and open drain fields
  input wire logic [`PIN_FIELD_W-1:0] int_pin_oe,
  input wire logic [`PIN_FIELD_W-1:0] int_pin_od,
  // register read port
  input wire logic rd_en,
  input wire logic [`ADDR_W-1:0] rd_addr,
  output rx_irq_pkg::byte_t rd_data,
  output logic rd_valid,
  // combined request and pin
  output logic combined_irq_raw,
  output logic receiver_irq_pin_o,
  output logic receiver_irq_pin_oe
);
  import rx_irq_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  generate
    if (CD_W < 1 || CD_W > `LANE_W)
    begin : g_chk
      $error("colour depth width out of range");
    end
    if (`FLAG_W != (`LANE_EDGE + 1) * `LANE_W)
    begin : g_chk_lanes
      $error("flag vector does not hold every register lane");
    end
    if ($bits(byte_t) != `LANE_W)
    begin : g_chk_byte
      $error("byte type does not match lane width");
    end
    if (`LINK_SRC_W > `LANE_W || `PKT_SRC_W > `LANE_W)
    begin : g_chk_src
      $error("source field wider than a register lane");
    end
    if (`BIT_CABLE >= `LINK_SRC_W || `BIT_GEN_CTL >= `PKT_SRC_W)
    begin : g_chk_link
      $error("source bit outside its field");
    end
    if (`BIT_CKS_HI - `BIT_CKS_LO + 1 != `CKS_W)
    begin : g_chk_cks
      $error("checksum field width mismatch");
    end
    if (`BIT_COLOUR >= `BIT_CKS_LO || `BIT_CLK_CHANGE >= `BIT_CKS_LO)
    begin : g_chk_cks_lo
      $error("colour or clock change bit inside checksum field");
    end
    if (`BIT_HDR_ERR < `PKT_EDGE_W)
    begin : g_chk_hdr
      $error("header error bit overlaps packet edge bits");
    end
    if (`BIT_HDR_ERR >= `LANE_W)
    begin : g_chk_hdr_lane
      $error("header error bit outside its lane");
    end
    if (`OFS_PACKET_EDGE - `OFS_LINK_EVENT != `LANE_EDGE)
    begin : g_chk_ofs
      $error("register offsets not consecutive");
    end
    if (`PIN_RX_IDX >= `PIN_FIELD_W)
    begin : g_chk_pin
      $error("receiver pin index outside pin field");
    end
  endgenerate

  // ****************************************
  // local widths
  // ****************************************
  localparam int SRC_W = CD_W + `LINK_SRC_W + `PKT_SRC_W;
  localparam int LINK_LO = `PKT_SRC_W;
  localparam int CD_LO = `PKT_SRC_W + `LINK_SRC_W;

  // ****************************************
  // helpers
  // ****************************************
  function automatic byte_t lane_of(input logic [`FLAG_W-1:0] v, input int lane);
    byte_t b;
    b = v[lane*`LANE_W +: `LANE_W];
    return b;
  endfunction

  function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
    return (a >= `OFS_LINK_EVENT) && (a <= `OFS_PACKET_EDGE);
  endfunction

  function automatic byte_t read_mux(input logic [`FLAG_W-1:0] v, input logic [`ADDR_W-1:0] a);
    byte_t d;
    if (a == `OFS_LINK_EVENT)
      d = lane_of(v, `LANE_LINK);
    else if (a == `OFS_PACKET_EVENT)
      d = lane_of(v, `LANE_PACKET);
    else if (a == `OFS_CHECKSUM_EDGE)
      d = lane_of(v, `LANE_CHECKSUM);
    else if (a == `OFS_PACKET_EDGE)
      d = lane_of(v, `LANE_EDGE);
    else
      d = `RST_BYTE;
    return d;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  top_state_s st_r;
  top_state_s st_nxt;
  logic [SRC_W-1:0] src_level;
  logic [SRC_W-1:0] src_change;
  logic [`LINK_SRC_W-1:0] link_chg;
  logic [`PKT_SRC_W-1:0] pkt_chg;
  logic colour_chg;
  byte_t set_link;
  byte_t set_packet;
  byte_t set_checksum;
  byte_t set_edge;
  logic [`FLAG_W-1:0] mask_all;
  logic [`FLAG_W-1:0] flags;
  logic irq_now;
  pin_mode_e pin_mode;
  logic rd_hit;
  byte_t rd_word;

  flag_bank_if #(.W(`FLAG_W)) bank ();

  // ****************************************
  // change detection on every level source
  // ****************************************
  assign src_level = {colour_depth, link_status, packet_status};

  change_detector #(.W(SRC_W)) u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .level(src_level),
    .change(src_change)
  );

  assign pkt_chg = src_change[`PKT_SRC_W-1:0];
  assign link_chg = src_change[LINK_LO +: `LINK_SRC_W];
  assign colour_chg = |src_change[CD_LO +: CD_W];

  // ****************************************
  // link event byte
  // ****************************************
  always_comb
  begin
    set_link = `RST_BYTE;
    set_link[`BIT_CABLE] = link_chg[`BIT_CABLE];
    set_link[`BIT_PLL_LOCK] = link_chg[`BIT_PLL_LOCK];
    set_link[`BIT_CLK_DET] = link_chg[`BIT_CLK_DET];
    set_link[`BIT_STEREO] = link_chg[`BIT_STEREO];
    set_link[`BIT_AV_MUTE] = link_chg[`BIT_AV_MUTE];
    set_link[`BIT_LINK_MODE] = link_chg[`BIT_LINK_MODE];
  end

  // ****************************************
  // packet event byte
  // ****************************************
  always_comb
  begin
    set_packet = `RST_BYTE;
    set_packet[`BIT_GEN_CTL] = pkt_chg[`BIT_GEN_CTL];
    set_packet[`BIT_GAMUT] = pkt_chg[`BIT_GAMUT];
    set_packet[`BIT_ISRC2] = pkt_chg[`BIT_ISRC2];
    set_packet[`BIT_ISRC1] = pkt_chg[`BIT_ISRC1];
    set_packet[`BIT_VENDOR] = pkt_chg[`BIT_VENDOR];
    set_packet[`BIT_MPEG] = pkt_chg[`BIT_MPEG];
    set_packet[`BIT_SRC_DESC] = pkt_chg[`BIT_SRC_DESC];
    set_packet[`BIT_VIDEO_INFO] = pkt_chg[`BIT_VIDEO_INFO];
  end

  // ****************************************
  // checksum edge byte
  // ****************************************
  always_comb
  begin
    set_checksum = `RST_BYTE;
    set_checksum[`BIT_CKS_HI:`BIT_CKS_LO] = checksum_err;
    set_checksum[`BIT_COLOUR] = colour_chg;
    set_checksum[`BIT_CLK_CHANGE] = link_chg[`BIT_CLK_DET];
  end

  // ****************************************
  // packet edge byte
  // ****************************************
  always_comb
  begin
    set_edge = `RST_BYTE;
    set_edge[`BIT_HDR_ERR] = header_err;
    set_edge[`BIT_GAMUT] = pkt_chg[`BIT_GAMUT];
    set_edge[`BIT_ISRC2] = pkt_chg[`BIT_ISRC2];
    set_edge[`BIT_ISRC1] = pkt_chg[`BIT_ISRC1];
    set_edge[`BIT_VENDOR] = pkt_chg[`BIT_VENDOR];
    set_edge[`BIT_MPEG] = pkt_chg[`BIT_MPEG];
    set_edge[`BIT_SRC_DESC] = pkt_chg[`BIT_SRC_DESC];
    set_edge[`BIT_VIDEO_INFO] = pkt_chg[`BIT_VIDEO_INFO];
  end

  // ****************************************
  // sticky flag storage
  // ****************************************
  assign bank.set = {set_edge, set_checksum, set_packet, set_link};
  assign bank.clr = {clr_edge, clr_checksum, clr_packet, clr_link};

  status_flag_bank #(.W(`FLAG_W)) u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .bank(bank)
  );

  assign flags = bank.flags;

  // ****************************************
  // combined request
  // ****************************************
  assign mask_all = {mask_edge, mask_checksum, mask_packet, mask_link};
  assign irq_now = |(flags & mask_all);

  // ****************************************
  // pin mode
  // ****************************************
  always_comb
  begin
    if (!int_pin_oe[`PIN_RX_IDX])
      pin_mode = PIN_OFF;
    else if (int_pin_od[`PIN_RX_IDX])
      pin_mode = PIN_DRAIN;
    else
      pin_mode = PIN_PUSH;
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb
  begin
    rd_hit = addr_mapped(rd_addr);
    rd_word = read_mux(flags, rd_addr);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rd_valid = rd_en;
    st_nxt.irq_raw = irq_now;
    if (rd_en && rd_hit)
      st_nxt.rd_data = rd_word;
    else
      st_nxt.rd_data = `RST_BYTE;
    case (pin_mode)
      PIN_PUSH:
      begin
        st_nxt.pin_o = irq_now;
        st_nxt.pin_oe = 1'h1;
      end
      PIN_DRAIN:
      begin
        st_nxt.pin_o = `RST_BIT;
        st_nxt.pin_oe = irq_now;
      end
      default:
      begin
        st_nxt.pin_o = `RST_BIT;
        st_nxt.pin_oe = `RST_BIT;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;
  assign combined_irq_raw = st_r.irq_raw;
  assign receiver_irq_pin_o = st_r.pin_o;
  assign receiver_irq_pin_oe = st_r.pin_oe;
endmodule

// *** rx_latch_asserts.sv ***
// port assertions for the rx status latch
`timescale 1ns/1ps
`include "rx_irq_consts.svh"
module rx_latch_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sources, masks, pin fields
  input wire logic [`LINK_SRC_W-1:0] link_status,
  input wire logic [`CKS_W-1:0] checksum_err,
  input wire logic header_err,
  input wire rx_irq_pkg::byte_t mask_link,
  input wire rx_irq_pkg::byte_t mask_checksum,
  input wire rx_irq_pkg::byte_t mask_edge,
  input wire logic [`PIN_FIELD_W-1:0] int_pin_oe,
  input wire logic [`PIN_FIELD_W-1:0] int_pin_od,
  // read port and outputs
  input wire logic rd_en,
  input wire logic [`ADDR_W-1:0] rd_addr,
  input wire rx_irq_pkg::byte_t rd_data,
  input wire logic rd_valid,
  input wire logic combined_irq_raw,
  input wire logic receiver_irq_pin_o,
  input wire logic receiver_irq_pin_oe
);
  import rx_irq_pkg::*;
  logic [1:0] up_r;
  logic on;
  logic od;
  assign on = int_pin_oe[`PIN_RX_IDX];
  assign od = int_pin_od[`PIN_RX_IDX];
  // ****
  // edges since reset release
  // ****
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_ANSWER: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  AST_RD_IDLE: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
    else $error("read port active without request");
  AST_RD_UNMAPPED: assert property (rd_en && (rd_addr < `OFS_LINK_EVENT || rd_addr > `OFS_PACKET_EDGE)
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  AST_LINK_TOP: assert property (rd_en && rd_addr == `OFS_LINK_EVENT |=> rd_data[7:6] == 2'h0)
    else $error("link byte top bits set");
  AST_LINK_SET: assert property (up_r == 2'h3 && (mask_link[5:0] & (link_status ^ $past(link_status))) != 6'h0
    ##1 $stable(mask_link) [*2] |=> combined_irq_raw) else $error("link change gave no request");
  AST_CKS_SET: assert property ((mask_checksum[5:2] & checksum_err) != 4'h0 ##1 $stable(mask_checksum)
    |=> combined_irq_raw) else $error("checksum error gave no request");
  AST_HDR_SET: assert property (header_err && mask_edge[7] ##1 mask_edge[7] |=> combined_irq_raw)
    else $error("header error gave no request");
  AST_PIN_OFF: assert property (!on [*2] |=> !receiver_irq_pin_o && !receiver_irq_pin_oe)
    else $error("pin driven while disabled");
  AST_PIN_PUSH: assert property ((on && !od) [*2] |=> receiver_irq_pin_oe && receiver_irq_pin_o == combined_irq_raw)
    else $error("push pull pin wrong");
  AST_PIN_DRAIN: assert property ((on && od) [*2] |=> !receiver_irq_pin_o && receiver_irq_pin_oe == combined_irq_raw)
    else $error("open drain pin wrong");
  cover property (rd_en && rd_addr == `OFS_PACKET_EDGE);
  cover property (receiver_irq_pin_oe && !receiver_irq_pin_o);
  cover property ($rose(combined_irq_raw));
endmodule

// *** rx_host_model.sv ***
// host side model reading the status registers
`timescale 1ns/1ps
module rx_host_model
(
  // clock
  input wire logic clk,
  // read port
  output logic rd_en,
  output logic [15:0] rd_addr,
  input wire rx_irq_pkg::byte_t rd_data,
  input wire logic rd_valid
);
  import rx_irq_pkg::*;
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 16'h0000;
  end
  // read only access, no write path
  task rd(input logic [15:0] a, output byte_t d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule

// *** tb.sv ***
// self checking bench for the rx status latch
`timescale 1ns/1ps
`include "rx_irq_consts.svh"
module tb;
  import rx_irq_pkg::*;
  logic clk;
  logic rst_n = 1'b0;
  logic [5:0] link_status = 6'h00;
  logic [7:0] packet_status = 8'h00;
  logic [2:0] colour_depth = 3'h0;
  logic [3:0] checksum_err = 4'h0;
  logic header_err = 1'b0;
  byte_t mask_link = 8'h00, mask_packet = 8'h00, mask_checksum = 8'h00, mask_edge = 8'h00;
  byte_t clr_link = 8'h00, clr_packet = 8'h00, clr_checksum = 8'h00, clr_edge = 8'h00;
  logic [2:0] int_pin_oe = 3'h0, int_pin_od = 3'h0;
  logic rd_en, rd_valid, combined_irq_raw, receiver_irq_pin_o, receiver_irq_pin_oe;
  logic [15:0] rd_addr;
  byte_t rd_data;
  logic [31:0] ew = 32'h0;
  byte_t pe [3] = '{8'h00, 8'h03, 8'h01};
  int failures = 0, n_compared = 0;
  rx_interrupt_status_latch DUT (.*);
  rx_host_model host (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****
  // helpers
  // ****
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input byte_t g, input byte_t w);
    n_compared++;
    if (g !== w)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, w);
    end
  endtask
  task rdc(input logic [15:0] a, input byte_t w);
    byte_t d;
    logic v;
    host.rd(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, w);
  endtask
  task all4();
    for (int k = 0; k < 4; k++) rdc(`OFS_LINK_EVENT + 16'(k), ew[8*k +: 8]);
  endtask
  task setm(input logic [31:0] m);
    @(posedge clk);
    {mask_edge, mask_checksum, mask_packet, mask_link} <= m;
  endtask
  task clr_all();
    @(posedge clk);
    {clr_edge, clr_checksum, clr_packet, clr_link} <= 32'hFFFFFFFF;
    @(posedge clk);
    {clr_edge, clr_checksum, clr_packet, clr_link} <= 32'h0;
    tick(3);
  endtask
  task ev(input int k, input int i);
    case (k)
      0: ew = (32'h1 << i) | ((i == 3) ? 32'h10000 : 32'h0);
      1: ew = (32'h100 << i) | ((i < 7) ? (32'h1000000 << i) : 32'h0);
      2: ew = 32'h40000 << i;
      3: ew = 32'h80000000;
      default: ew = 32'h20000;
    endcase
    setm(ew);
    @(posedge clk);
    case (k)
      0: link_status[i] <= ~link_status[i];
      1: packet_status[i] <= ~packet_status[i];
      2: checksum_err <= 4'h1 << i;
      3: header_err <= 1'b1;
      default: colour_depth <= colour_depth + 3'h1;
    endcase
    @(posedge clk);
    checksum_err <= 4'h0;
    header_err <= 1'b0;
    tick(4);
    chk({7'h0, combined_irq_raw}, 8'h01);
    all4();
    all4();
    setm(~ew);
    tick(3);
    chk({7'h0, combined_irq_raw}, 8'h00);
    setm(32'h0);
    clr_all();
    ew = 32'h0;
    all4();
  endtask
  task results();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    all4();
    rdc(16'h1AFA, 8'h00);
    rdc(16'h1AF5, 8'h00);
    for (int i = 0; i < 6; i++) ev(0, i);
    for (int i = 0; i < 8; i++) ev(1, i);
    for (int i = 0; i < 4; i++) ev(2, i);
    ev(3, 0);
    ev(4, 0);
    @(posedge clk);
    checksum_err <= 4'h1;
    clr_checksum <= 8'h04;
    @(posedge clk);
    checksum_err <= 4'h0;
    clr_checksum <= 8'h00;
    mask_checksum <= 8'h04;
    tick(3);
    rdc(`OFS_CHECKSUM_EDGE, 8'h04);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      int_pin_oe <= (k > 0) ? 3'h4 : 3'h0;
      int_pin_od <= (k == 2) ? 3'h4 : 3'h0;
      tick(3);
      chk({6'h0, receiver_irq_pin_o, receiver_irq_pin_oe}, pe[k]);
    end
    clr_all();
    chk({6'h0, receiver_irq_pin_o, receiver_irq_pin_oe}, 8'h00);
    @(posedge clk);
    link_status[5] <= ~link_status[5];
    mask_link <= 8'h20;
    tick(4);
    chk({7'h0, combined_irq_raw}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk({7'h0, combined_irq_raw}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    all4();
    results();
  end
  initial
  begin
    #50us;
    failures++;
    results();
  end
endmodule
bind rx_interrupt_status_latch rx_latch_asserts chkr (.*);
